/* hw/dit_pkg.sv */
// Function
// - one setting picks up or down counting
// - up mode counts from zero to interval
// - down mode loads interval, counts to zero
// - time base picks hours:minutes or minutes:seconds
// - first interval spans 00:00 to 99:59
// - first interval shown only when flag set
// - first lamp reflects first timer condition
// - second lamp reflects second timer condition
// - second timer starts when first completes
// - second lamp flashes running or paused, else off
// - trigger off disables timers, hides first interval
package dit_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 8;  // 125 MHz system clock
    localparam int unsigned SEC_NS = 1_000_000_000;  // one second
    localparam int unsigned SEC_CYCLES = SEC_NS / CLK_PERIOD_NS;
    localparam int unsigned PRESC_W = 27;  // holds one second of cycles
    localparam int unsigned BLINK_W = 26;  // free-running blink counter
    localparam int unsigned BLINK_SLOW_BIT = 25;  // about 0.27 s half period
    localparam int unsigned BLINK_FAST_BIT = 23;  // quick flash when paused

    // ----------------------------------------------------------------
    // time field limits
    // ----------------------------------------------------------------
    localparam logic [5:0] LOW_MAX = 6'h3b;  // 59, lower field top
    localparam logic [6:0] HIGH_MAX = 7'h63;  // 99, upper field top

    // ----------------------------------------------------------------
    // register map (byte addresses) and field positions
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 5;
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_T1 = 5'h04;
    localparam logic [4:0] OFS_T2 = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0c;
    localparam logic [4:0] OFS_COUNT = 5'h10;
    localparam int unsigned CTRL_TRIG = 0;  // timers enabled
    localparam int unsigned CTRL_DIR_DN = 1;  // count_descending_option
    localparam int unsigned CTRL_BASE_MS = 2;  // timer_time_base_setting
    localparam int unsigned CTRL_SHOW = 3;  // show first interval
    localparam int unsigned CTRL_END_ON = 4;  // first lamp on after T1
    localparam int unsigned CMD_START = 5;  // write one: start cycle
    localparam int unsigned CMD_PAUSE = 6;  // write one: pause/resume
    localparam int unsigned CMD_ABORT = 7;  // write one: end cycle now
    localparam int unsigned TIME_LO_LSB = 0;
    localparam int unsigned TIME_HI_LSB = 8;
    localparam int unsigned ST_VIS_BIT = 3;
    localparam int unsigned ST_LAMP1_BIT = 4;
    localparam int unsigned ST_LAMP2_BIT = 5;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [6:0] hi;  // hours or minutes
        logic [5:0] lo;  // minutes or seconds
    } dit_time_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_T1_RUN = 3'h1,
        ST_T1_PAUSE = 3'h2,
        ST_T2_RUN = 3'h3,
        ST_T2_PAUSE = 3'h4,
        ST_DONE = 3'h5
    } dit_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } dit_avs_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } dit_avs_resp_t;

    typedef struct packed {
        dit_state_t st;
        logic trig;
        logic dir_dn;
        logic base_ms;
        logic show;
        logic end_on;
        dit_time_t t1;
        dit_time_t t2;
        dit_time_t cnt;
        logic [PRESC_W-1:0] presc;
        logic [5:0] sec;
        logic [BLINK_W-1:0] blink;
        logic lamp1;
        logic lamp2;
        logic vis;
        dit_avs_resp_t resp;
    } dit_regs_t;

endpackage

/* hw/dit_timer.sv */
module dit_timer #(
    parameter int unsigned SEC_CYCLES = dit_pkg::SEC_CYCLES,
    parameter int unsigned BLINK_SLOW = dit_pkg::BLINK_SLOW_BIT,  // run flash
    parameter int unsigned BLINK_FAST = dit_pkg::BLINK_FAST_BIT  // pause flash
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // avalon-mm slave
    input wire dit_pkg::dit_avs_req_t avs_req,
    output dit_pkg::dit_avs_resp_t avs_resp,
    // front panel
    output logic first_timer_lamp,
    output logic second_timer_lamp,
    output logic first_timer_param_visible
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (SEC_CYCLES < 2 || SEC_CYCLES > (1 << dit_pkg::PRESC_W)
        || BLINK_FAST >= BLINK_SLOW
        || BLINK_SLOW >= dit_pkg::BLINK_W) begin : g_bad
        $error("timing parameters out of range");
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one step up, lower field rolls into upper after 59
    function automatic dit_pkg::dit_time_t step_up(dit_pkg::dit_time_t t);
        dit_pkg::dit_time_t r;
        r = t;
        if (t.lo == dit_pkg::LOW_MAX) begin
            r.lo = 6'h00;
            r.hi = 7'(t.hi + 7'h01);
        end else begin
            r.lo = 6'(t.lo + 6'h01);
        end
        return r;
    endfunction

    // one step down, borrow from upper field
    function automatic dit_pkg::dit_time_t step_dn(dit_pkg::dit_time_t t);
        dit_pkg::dit_time_t r;
        r = t;
        if (t.lo == 6'h00) begin
            r.lo = dit_pkg::LOW_MAX;
            r.hi = 7'(t.hi - 7'h01);
        end else begin
            r.lo = 6'(t.lo - 6'h01);
        end
        return r;
    endfunction

    // clamp a written value into 00:00..99:59
    function automatic dit_pkg::dit_time_t clamp(logic [6:0] hi,
                                                 logic [5:0] lo);
        dit_pkg::dit_time_t r;
        r.hi = (hi > dit_pkg::HIGH_MAX) ? dit_pkg::HIGH_MAX : hi;
        r.lo = (lo > dit_pkg::LOW_MAX) ? dit_pkg::LOW_MAX : lo;
        return r;
    endfunction

    // place a time value in a bus word
    function automatic logic [31:0] to_word(dit_pkg::dit_time_t t);
        return {17'h0, t.hi, 2'h0, t.lo};
    endfunction

    // byte-lane merge of an interval write
    function automatic dit_pkg::dit_time_t wr_time(dit_pkg::dit_time_t o,
                                                   dit_pkg::dit_avs_req_t q);
        logic [6:0] hi;
        logic [5:0] lo;
        hi = q.byteenable[1] ? q.writedata[dit_pkg::TIME_HI_LSB +: 7] : o.hi;
        lo = q.byteenable[0] ? q.writedata[dit_pkg::TIME_LO_LSB +: 6] : o.lo;
        return clamp(hi, lo);
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    dit_pkg::dit_regs_t s_q;  // all registers
    dit_pkg::dit_regs_t s_d;  // next value
    logic bus_go;  // access completes at this edge
    logic ctrl_wr;  // control low byte written
    logic cmd_start;  // start command
    logic cmd_pause;  // pause or resume command
    logic cmd_abort;  // end cycle command
    logic sec_tick;  // one second elapsed
    logic tick;  // count step in selected base
    logic done;  // count reached its end value
    dit_pkg::dit_time_t target;  // end value of running timer
    dit_pkg::dit_time_t stepped;  // count after one step

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        bus_go = (avs_req.read || avs_req.write) && !s_q.resp.waitrequest;
        ctrl_wr = bus_go && avs_req.write && avs_req.byteenable[0]
                  && avs_req.address == dit_pkg::OFS_CTRL;
        cmd_start = ctrl_wr && avs_req.writedata[dit_pkg::CMD_START];
        cmd_pause = ctrl_wr && avs_req.writedata[dit_pkg::CMD_PAUSE];
        cmd_abort = ctrl_wr && avs_req.writedata[dit_pkg::CMD_ABORT];
        // prescaler wrap and minute/second step select
        sec_tick = s_q.presc == dit_pkg::PRESC_W'(SEC_CYCLES - 1);
        tick = s_q.base_ms ? sec_tick
                           : (sec_tick && s_q.sec == dit_pkg::LOW_MAX);
        // end value depends on direction and which timer runs
        if (s_q.dir_dn) begin
            target = '0;
        end else begin
            target = (s_q.st == dit_pkg::ST_T1_RUN) ? s_q.t1 : s_q.t2;
        end
        done = s_q.cnt == target;
        stepped = s_q.dir_dn ? step_dn(s_q.cnt) : step_up(s_q.cnt);
        s_d.blink = dit_pkg::BLINK_W'(s_q.blink + 1'b1);

        // bus handshake: one wait cycle, then a one-cycle answer
        s_d.resp.waitrequest = !((avs_req.read || avs_req.write)
                                 && s_q.resp.waitrequest);
        if ((avs_req.read || avs_req.write) && s_q.resp.waitrequest) begin
            unique case (avs_req.address)
                dit_pkg::OFS_CTRL: s_d.resp.readdata = {27'h0,
                    s_q.end_on, s_q.show, s_q.base_ms, s_q.dir_dn, s_q.trig};
                dit_pkg::OFS_T1: s_d.resp.readdata = to_word(s_q.t1);
                dit_pkg::OFS_T2: s_d.resp.readdata = to_word(s_q.t2);
                dit_pkg::OFS_STATUS: s_d.resp.readdata = {26'h0,
                    s_q.lamp2, s_q.lamp1, s_q.vis, s_q.st};
                dit_pkg::OFS_COUNT: s_d.resp.readdata = to_word(s_q.cnt);
                default: s_d.resp.readdata = 32'h00000000;
            endcase
        end

        // register writes take effect at the answering edge
        if (ctrl_wr) begin
            s_d.trig = avs_req.writedata[dit_pkg::CTRL_TRIG];
            s_d.dir_dn = avs_req.writedata[dit_pkg::CTRL_DIR_DN];
            s_d.base_ms = avs_req.writedata[dit_pkg::CTRL_BASE_MS];
            s_d.show = avs_req.writedata[dit_pkg::CTRL_SHOW];
            s_d.end_on = avs_req.writedata[dit_pkg::CTRL_END_ON];
        end
        if (bus_go && avs_req.write) begin
            if (avs_req.address == dit_pkg::OFS_T1) begin
                s_d.t1 = wr_time(s_q.t1, avs_req);
            end
            if (avs_req.address == dit_pkg::OFS_T2) begin
                s_d.t2 = wr_time(s_q.t2, avs_req);
            end
        end

        // prescaler runs only while a timer runs
        if (s_q.st == dit_pkg::ST_T1_RUN || s_q.st == dit_pkg::ST_T2_RUN) begin
            s_d.presc = sec_tick ? '0 : dit_pkg::PRESC_W'(s_q.presc + 1'b1);
            if (sec_tick) begin
                s_d.sec = (s_q.sec == dit_pkg::LOW_MAX) ? 6'h00
                                                        : 6'(s_q.sec + 6'h01);
            end
        end

        // sequencer
        if (!s_q.trig) begin
            s_d.st = dit_pkg::ST_IDLE;
            s_d.presc = '0;
            s_d.sec = 6'h00;
        end else begin
            unique case (s_q.st)
                dit_pkg::ST_IDLE, dit_pkg::ST_DONE: begin
                    // a new cycle always begins with the first timer
                    if (cmd_start) begin
                        s_d.st = dit_pkg::ST_T1_RUN;
                        s_d.cnt = s_q.dir_dn ? s_q.t1 : '0;
                        s_d.presc = '0;
                        s_d.sec = 6'h00;
                    end
                end
                dit_pkg::ST_T1_RUN, dit_pkg::ST_T2_RUN: begin
                    if (cmd_abort) begin
                        s_d.st = dit_pkg::ST_DONE;
                    end else if (cmd_pause) begin
                        s_d.st = (s_q.st == dit_pkg::ST_T1_RUN)
                                 ? dit_pkg::ST_T1_PAUSE : dit_pkg::ST_T2_PAUSE;
                    end else if (done && s_q.st == dit_pkg::ST_T1_RUN) begin
                        // first interval over: hand over to second
                        s_d.st = dit_pkg::ST_T2_RUN;
                        s_d.cnt = s_q.dir_dn ? s_q.t2 : '0;
                        s_d.presc = '0;
                        s_d.sec = 6'h00;
                    end else if (done) begin
                        s_d.st = dit_pkg::ST_DONE;
                    end else if (tick) begin
                        s_d.cnt = stepped;
                    end
                end
                dit_pkg::ST_T1_PAUSE, dit_pkg::ST_T2_PAUSE: begin
                    if (cmd_abort) begin
                        s_d.st = dit_pkg::ST_DONE;
                    end else if (cmd_pause) begin
                        s_d.st = (s_q.st == dit_pkg::ST_T1_PAUSE)
                                 ? dit_pkg::ST_T1_RUN : dit_pkg::ST_T2_RUN;
                    end
                end
                default: s_d.st = dit_pkg::ST_IDLE;
            endcase
        end

        // lamps: slow flash running, quick flash paused
        unique case (s_q.st)
            dit_pkg::ST_T1_RUN: s_d.lamp1 = s_q.blink[BLINK_SLOW];
            dit_pkg::ST_T1_PAUSE: s_d.lamp1 = s_q.blink[BLINK_FAST];
            dit_pkg::ST_IDLE: s_d.lamp1 = 1'b0;
            default: s_d.lamp1 = s_q.end_on;
        endcase
        unique case (s_q.st)
            dit_pkg::ST_T2_RUN: s_d.lamp2 = s_q.blink[BLINK_SLOW];
            dit_pkg::ST_T2_PAUSE: s_d.lamp2 = s_q.blink[BLINK_FAST];
            default: s_d.lamp2 = 1'b0;
        endcase
        s_d.vis = s_q.trig && s_q.show;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s_q <= '0;
            s_q.resp.waitrequest <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_resp = s_q.resp;
    assign first_timer_lamp = s_q.lamp1;
    assign second_timer_lamp = s_q.lamp2;
    assign first_timer_param_visible = s_q.vis;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_dir_down_load: assert property (
        (s_q.st == dit_pkg::ST_IDLE || s_q.st == dit_pkg::ST_DONE)
        && s_q.trig && s_q.dir_dn && cmd_start
        |=> s_q.cnt == $past(s_q.t1) && s_q.st == dit_pkg::ST_T1_RUN)
        else $error("down start did not load interval");
    a_dir_up_zero: assert property (
        s_q.st == dit_pkg::ST_DONE && s_q.trig && !s_q.dir_dn && cmd_start
        |=> s_q.cnt == '0)
        else $error("up start did not clear count");
    a_dir_select: assert property (
        s_q.st == dit_pkg::ST_T1_RUN && tick && !done && !cmd_pause
        && !cmd_abort && s_q.trig && s_q.dir_dn
        |=> s_q.cnt == step_dn($past(s_q.cnt)))
        else $error("down step wrong");
    a_base_hold: assert property (
        s_q.st == dit_pkg::ST_T1_RUN && !tick ##1 s_q.st == dit_pkg::ST_T1_RUN
        |-> s_q.cnt == $past(s_q.cnt))
        else $error("count moved without a tick");
    a_time_range: assert property (
        s_q.t1.hi <= dit_pkg::HIGH_MAX && s_q.t1.lo <= dit_pkg::LOW_MAX)
        else $error("interval out of range");
    a_roll_over: assert property (
        s_q.st == dit_pkg::ST_T2_RUN && tick && !done && !cmd_pause
        && !cmd_abort && s_q.trig && !s_q.dir_dn
        && s_q.cnt.lo == dit_pkg::LOW_MAX
        |=> s_q.cnt.lo == 6'h00 && s_q.cnt.hi == $past(s_q.cnt.hi) + 7'h01)
        else $error("lower field did not roll over");
    a_show_flag: assert property (
        ##1 s_q.vis == $past(s_q.trig && s_q.show))
        else $error("visibility wrong");
    a_t2_after_t1: assert property (
        s_q.st == dit_pkg::ST_T2_RUN && $past(s_q.st) == dit_pkg::ST_T1_RUN
        |-> $past(done))
        else $error("second timer started early");
    a_lamp2_off: assert property (
        s_q.st == dit_pkg::ST_IDLE || s_q.st == dit_pkg::ST_DONE
        |=> !second_timer_lamp)
        else $error("second lamp lit while stopped");
    a_lamp1_end: assert property (
        s_q.st == dit_pkg::ST_T2_RUN |=> first_timer_lamp == $past(s_q.end_on))
        else $error("first lamp wrong after first timer");
    a_lamp2_run: assert property (
        s_q.st == dit_pkg::ST_T2_RUN
        |=> second_timer_lamp == $past(s_q.blink[BLINK_SLOW]))
        else $error("second lamp not flashing");
    a_trig_off: assert property (
        !s_q.trig |=> s_q.st == dit_pkg::ST_IDLE ##1 !first_timer_lamp)
        else $error("timers not disabled");

endmodule

/* tb/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // settings and signals
    // ------------------------------------------------------------
    localparam int SC = 8;  // shortened second keeps runs brief
    localparam logic [31:0] TRIG = 32'h1 << dit_pkg::CTRL_TRIG;
    localparam logic [31:0] DN = 32'h1 << dit_pkg::CTRL_DIR_DN;
    localparam logic [31:0] MS = 32'h1 << dit_pkg::CTRL_BASE_MS;
    localparam logic [31:0] SHOW = 32'h1 << dit_pkg::CTRL_SHOW;
    localparam logic [31:0] ENDON = 32'h1 << dit_pkg::CTRL_END_ON;
    localparam logic [31:0] GO = 32'h1 << dit_pkg::CMD_START;
    localparam logic [31:0] PAUSE = 32'h1 << dit_pkg::CMD_PAUSE;
    localparam logic [31:0] ABORT = 32'h1 << dit_pkg::CMD_ABORT;
    localparam logic [31:0] VIS = 32'h1 << dit_pkg::ST_VIS_BIT;
    localparam logic [31:0] L1 = 32'h1 << dit_pkg::ST_LAMP1_BIT;
    localparam logic [31:0] L2 = 32'h1 << dit_pkg::ST_LAMP2_BIT;
    localparam logic [31:0] TM = 32'h7f3f;  // both time fields
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    dit_pkg::dit_avs_req_t avs_req = '0;
    dit_pkg::dit_avs_resp_t avs_resp;
    logic first_timer_lamp;
    logic second_timer_lamp;
    logic first_timer_param_visible;
    logic [31:0] exp_q[$];  // expected read data, oldest first
    logic [31:0] msk_q[$];  // mask per note, zero means poll only
    logic [31:0] me, mm, d, v, from, to, seed;
    int num_errors = 0;
    int compares = 0;
    int cyc = 0;
    int t0;

    // free-running clock and cycle count
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) cyc <= cyc + 1;

    dit_timer #(.SEC_CYCLES(SC), .BLINK_SLOW(2), .BLINK_FAST(1)) i_dut (
        .clk_sys(clk_sys),
        .rst(rst),
        .avs_req(avs_req),
        .avs_resp(avs_resp),
        .first_timer_lamp(first_timer_lamp),
        .second_timer_lamp(second_timer_lamp),
        .first_timer_param_visible(first_timer_param_visible)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] tm(input int h, input int l);
        return (32'(h) << dit_pkg::TIME_HI_LSB) | 32'(l);
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    // one avalon access; held until waitrequest is seen low
    task automatic bus(input logic we, input logic [4:0] a,
                       input logic [31:0] wd, input logic [31:0] e,
                       input logic [31:0] m);
        int n;
        @(posedge clk_sys);
        avs_req.read <= ~we;
        avs_req.write <= we;
        avs_req.address <= a;
        avs_req.writedata <= wd;
        avs_req.byteenable <= 4'hf;
        if (!we) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        n = 0;
        // waitrequest seen low at a rising edge ends the access there
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_resp.waitrequest !== 1'b0 && n < 50);
        if (avs_resp.waitrequest !== 1'b0) chk("waitrequest", 32'h0, 32'h1);
        d = avs_resp.readdata;
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd, 32'h0, 32'h0);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        bus(1'b0, a, 32'h0, e, m);
    endtask

    // poll until the masked value does or does not equal val
    task automatic wait_val(input logic [4:0] a, input logic [31:0] m,
                            input logic [31:0] val, input logic eq,
                            input int lim);
        int n;
        n = 0;
        do begin
            bus(1'b0, a, 32'h0, 32'h0, 32'h0);
            n++;
        end while ((((d & m) === val) != eq) && n < lim);
        if (((d & m) === val) != eq) begin
            num_errors++;
            $display("mismatch poll exp %h got %h", val, d & m);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // read monitor: oldest note against each answered read
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (avs_req.read && avs_resp.waitrequest === 1'b0) begin
            me = exp_q.pop_front();
            mm = msk_q.pop_front();
            if (mm != 32'h0) chk("readdata", me & mm, avs_resp.readdata & mm);
        end
    end

    // watchdog cuts a hang short
    initial begin
        repeat (30000) @(posedge clk_sys);
        chk("watchdog", 32'h0, 32'h1);
        complete_run();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h400dbe7d;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        // reset values, unmapped place included
        for (int a = 0; a < 24; a += 4) begin
            rd(5'(a), 32'h0, 32'hffffffff);
        end
        chk("visible", 32'h0, 32'(first_timer_param_visible));
        // interval range and clamping
        wr(dit_pkg::OFS_T1, tm(127, 63));
        rd(dit_pkg::OFS_T1, tm(99, 59), TM);
        repeat (4) begin
            seed = lfsr(seed);
            v = tm(int'(seed[6:0]) % 100, int'(seed[13:8]) % 60);
            wr(dit_pkg::OFS_T2, v);
            rd(dit_pkg::OFS_T2, v, TM);
        end
        wr(5'h14, seed);
        rd(5'h14, 32'h0, 32'hffffffff);
        // commands refused with trigger off
        wr(dit_pkg::OFS_CTRL, GO | SHOW);
        rd(dit_pkg::OFS_STATUS, 32'h0, 32'h7 | VIS);
        wr(dit_pkg::OFS_CTRL, TRIG | SHOW);
        rd(dit_pkg::OFS_STATUS, VIS, VIS);
        chk("visible", 32'h1, 32'(first_timer_param_visible));
        wr(dit_pkg::OFS_CTRL, TRIG);
        rd(dit_pkg::OFS_STATUS, 32'h0, VIS);
        // up run in min:sec, second timer after first
        wr(dit_pkg::OFS_T1, tm(0, 2));
        wr(dit_pkg::OFS_T2, tm(0, 1));
        wr(dit_pkg::OFS_CTRL, TRIG | MS);
        wr(dit_pkg::OFS_CTRL, TRIG | MS | GO);
        t0 = cyc;
        rd(dit_pkg::OFS_STATUS, dit_pkg::ST_T1_RUN, 32'h7 | L2);
        wait_val(dit_pkg::OFS_STATUS, 32'h7, dit_pkg::ST_T2_RUN, 1'b1, 40);
        chk("t1_span", 32'h1,
            32'(cyc - t0 >= 2 * SC - 2 && cyc - t0 <= 2 * SC + 8));
        wait_val(dit_pkg::OFS_STATUS, 32'h7, dit_pkg::ST_DONE, 1'b1, 40);
        rd(dit_pkg::OFS_STATUS, 32'h0, L1 | L2);
        rd(dit_pkg::OFS_COUNT, tm(0, 1), TM);
        // down run, one setting serves both timers
        wr(dit_pkg::OFS_T1, tm(0, 1));
        wr(dit_pkg::OFS_T2, tm(0, 2));
        wr(dit_pkg::OFS_CTRL, TRIG | MS | DN | ENDON);
        wr(dit_pkg::OFS_CTRL, TRIG | MS | DN | ENDON | GO);
        rd(dit_pkg::OFS_COUNT, tm(0, 1), TM);
        wait_val(dit_pkg::OFS_STATUS, 32'h7, dit_pkg::ST_T2_RUN, 1'b1, 40);
        rd(dit_pkg::OFS_COUNT, tm(0, 2), TM);
        rd(dit_pkg::OFS_STATUS, L1, L1);
        chk("lamp1", 32'h1, 32'(first_timer_lamp));
        wait_val(dit_pkg::OFS_STATUS, 32'h7, dit_pkg::ST_DONE, 1'b1, 40);
        rd(dit_pkg::OFS_COUNT, 32'h0, TM);
        // field roll-over in both directions, with pause and abort
        for (int k = 0; k < 2; k++) begin
            v = TRIG | MS | (k == 1 ? DN : 32'h0);
            wr(dit_pkg::OFS_T1, tm(2, 0));
            wr(dit_pkg::OFS_CTRL, v);
            wr(dit_pkg::OFS_CTRL, v | GO);
            from = (k == 1) ? tm(2, 0) : tm(0, 59);
            to = (k == 1) ? tm(1, 59) : tm(1, 0);
            wait_val(dit_pkg::OFS_COUNT, TM, from, 1'b1, 300);
            wait_val(dit_pkg::OFS_COUNT, TM, from, 1'b0, 10);
            chk("count", to, d & TM);
            wr(dit_pkg::OFS_CTRL, v | PAUSE);
            rd(dit_pkg::OFS_STATUS, dit_pkg::ST_T1_PAUSE, 32'h7);
            wr(dit_pkg::OFS_CTRL, v | PAUSE);
            rd(dit_pkg::OFS_STATUS, dit_pkg::ST_T1_RUN, 32'h7);
            wr(dit_pkg::OFS_CTRL, v | ABORT);
            rd(dit_pkg::OFS_STATUS, dit_pkg::ST_DONE, 32'h7 | L2);
        end
        // hours:minutes steps once a minute
        wr(dit_pkg::OFS_T1, tm(0, 1));
        wr(dit_pkg::OFS_CTRL, TRIG);
        wr(dit_pkg::OFS_CTRL, TRIG | GO);
        t0 = cyc;
        wait_val(dit_pkg::OFS_STATUS, 32'h7, dit_pkg::ST_T2_RUN, 1'b1, 300);
        chk("t1_span", 32'h1,
            32'(cyc - t0 >= 60 * SC - 2 && cyc - t0 <= 60 * SC + 8));
        // second lamp pin must show both levels while the second timer runs
        from = 32'h0;
        to = 32'h0;
        repeat (8) begin
            @(posedge clk_sys);
            from[0] = from[0] | second_timer_lamp;
            to[0] = to[0] | ~second_timer_lamp;
        end
        chk("lamp2_flash", 32'h1, from & to);
        // trigger off in mid-run forces idle; lamps settle two cycles later
        wr(dit_pkg::OFS_CTRL, 32'h0);
        repeat (2) @(posedge clk_sys);
        rd(dit_pkg::OFS_STATUS, 32'h0, 32'h7 | L2);
        chk("lamp1", 32'h0, 32'(first_timer_lamp));
        chk("lamp2", 32'h0, 32'(second_timer_lamp));
        complete_run();
    end
endmodule
